// ===== src/bfp_top.sv
`timescale 1ns/100ps
module bfp_top #(
  parameter int UV_DELAY_CYCLES = bfp_pkg::UV_DELAY_CYCLES,
  parameter int UV_ENABLE_CYCLES = bfp_pkg::UV_ENABLE_CYCLES,
  parameter int HICCUP_CYCLES = bfp_pkg::HICCUP_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic high_side_req_in,
  input wire logic low_side_req_in,
  input wire logic continuous_conduction_in,
  input wire logic soft_start_done_in,
  input wire logic positive_current_limit_in,
  input wire logic negative_current_limit_in,
  input wire logic fb_under_in,
  input wire logic fb_over_in,
  input wire logic supply_lockout_in,
  input wire logic over_temp_in,
  output logic high_side_out,
  output logic low_side_out,
  output logic undervoltage_protect_out,
  output logic overvoltage_protect_out,
  output logic restart_out,
  output logic shutdown_out
);
  logic ocl_s;
  logic ncl_s;
  logic uv_s;
  logic ov_s;
  logic lockout_s;
  logic temp_s;
  logic uv_armed;
  logic uv_expired;
  logic hiccup_done;
  logic off_state_ff;
  logic ocl_hold_ff;
  logic uv_enable_ff;
  logic hard_off;
  logic nxt_high;
  logic nxt_low;
  bfp_pkg::bfp_state_type state_ff;
  bfp_pkg::bfp_state_type nxt_state;

  bfp_sync u_sync_ocl (.clock_in(clock_in), .rst_in(rst_in),
    .d_in(positive_current_limit_in), .q_out(ocl_s));
  bfp_sync u_sync_ncl (.clock_in(clock_in), .rst_in(rst_in),
    .d_in(negative_current_limit_in), .q_out(ncl_s));
  bfp_sync u_sync_uv (.clock_in(clock_in), .rst_in(rst_in), .d_in(fb_under_in), .q_out(uv_s));
  bfp_sync u_sync_ov (.clock_in(clock_in), .rst_in(rst_in), .d_in(fb_over_in), .q_out(ov_s));
  bfp_sync u_sync_lo (.clock_in(clock_in), .rst_in(rst_in),
    .d_in(supply_lockout_in), .q_out(lockout_s));
  bfp_sync u_sync_tp (.clock_in(clock_in), .rst_in(rst_in), .d_in(over_temp_in), .q_out(temp_s));

  // undervoltage checking is armed 1.5 ms after soft-start done
  bfp_delay_cnt #(.CNT_W(bfp_pkg::CNT_W), .LIMIT(32'(UV_ENABLE_CYCLES))) u_uv_en (
    .clock_in(clock_in), .rst_in(rst_in),
    .cond_in(soft_start_done_in && state_ff == bfp_pkg::BFP_RUN),
    .done_out(uv_armed));

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      uv_enable_ff <= 1'b0;
    end else begin
      uv_enable_ff <= uv_armed;
    end
  end

  bfp_delay_cnt #(.CNT_W(bfp_pkg::CNT_W), .LIMIT(32'(UV_DELAY_CYCLES))) u_uv_dly (
    .clock_in(clock_in), .rst_in(rst_in),
    .cond_in(uv_s && uv_enable_ff && state_ff == bfp_pkg::BFP_RUN),
    .done_out(uv_expired));

  bfp_delay_cnt #(.CNT_W(bfp_pkg::CNT_W), .LIMIT(32'(HICCUP_CYCLES))) u_hiccup (
    .clock_in(clock_in), .rst_in(rst_in),
    .cond_in(state_ff == bfp_pkg::BFP_HICCUP),
    .done_out(hiccup_done));

  // non-latching shutdowns
  assign hard_off = lockout_s || temp_s;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bfp_pkg::BFP_RUN: begin
        if (ov_s) begin
          nxt_state = bfp_pkg::BFP_OV_LOW_ON;
        end else if (uv_expired) begin
          nxt_state = bfp_pkg::BFP_UV_OFF;
        end
      end
      bfp_pkg::BFP_UV_OFF: begin
        nxt_state = bfp_pkg::BFP_HICCUP;
      end
      bfp_pkg::BFP_HICCUP: begin
        if (hiccup_done) begin
          nxt_state = bfp_pkg::BFP_RUN;
        end
      end
      bfp_pkg::BFP_OV_LOW_ON: begin
        if (uv_s) begin
          nxt_state = ov_s ? bfp_pkg::BFP_OV_HOLD : bfp_pkg::BFP_UV_OFF;
        end
      end
      bfp_pkg::BFP_OV_HOLD: begin
        if (!ov_s) begin
          nxt_state = bfp_pkg::BFP_UV_OFF;
        end
      end
      default: nxt_state = bfp_pkg::BFP_UV_OFF;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= bfp_pkg::BFP_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // off state = low side request active; current limits only judged there
  // the off state is stretched while the limit holds, so a high request cannot end it
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      off_state_ff <= 1'b0;
    end else begin
      off_state_ff <= (low_side_req_in && !high_side_req_in) || (off_state_ff && ocl_s);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ocl_hold_ff <= 1'b0;
    end else if (off_state_ff) begin
      ocl_hold_ff <= ocl_s;
    end else begin
      ocl_hold_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_high = high_side_req_in && !ocl_hold_ff && !(off_state_ff && ocl_s);
    nxt_low = (low_side_req_in || (off_state_ff && ocl_s))
        && !(continuous_conduction_in && off_state_ff && ncl_s);
    if (state_ff == bfp_pkg::BFP_OV_LOW_ON) begin
      nxt_high = 1'b0;
      nxt_low = 1'b1;
    end
    if (hard_off || state_ff == bfp_pkg::BFP_UV_OFF || state_ff == bfp_pkg::BFP_HICCUP
        || state_ff == bfp_pkg::BFP_OV_HOLD) begin
      nxt_high = 1'b0;
      nxt_low = 1'b0;
    end
    if (nxt_high) begin
      nxt_low = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      high_side_out <= 1'b0;
      low_side_out <= 1'b0;
      undervoltage_protect_out <= 1'b0;
      overvoltage_protect_out <= 1'b0;
      restart_out <= 1'b0;
      shutdown_out <= 1'b0;
    end else begin
      high_side_out <= nxt_high;
      low_side_out <= nxt_low;
      undervoltage_protect_out <= uv_s && uv_enable_ff;
      overvoltage_protect_out <= ov_s;
      restart_out <= state_ff == bfp_pkg::BFP_HICCUP && hiccup_done;
      shutdown_out <= !nxt_high && !nxt_low && (state_ff != bfp_pkg::BFP_RUN || hard_off);
    end
  end
endmodule

// ===== src/bfp_pkg.sv
// Functional notes
// - The overcurrent comparison is only looked at while the low side conducts, on every switching cycle.
// - While current stays above the trip level the off state is extended and the next high-side turn-on is held back.
// - A lasting overcurrent that pulls the output to undervoltage leads to shutdown, hiccup wait and restart, repeated while it lasts.
// - In continuous conduction a negative limit of equal magnitude is checked against the current valley.
// - Feedback below 70 percent of target raises the undervoltage indication and starts the undervoltage delay count.
// - When that count reaches 1 ms with the condition still present, both drive commands are latched off.
// - After an undervoltage latch-off the block waits the 16 ms hiccup delay and then starts afresh.
// - Undervoltage protection stays disabled until 1.5 ms after soft-start completes.
// - Feedback above 120 percent of target latches the high side off and the low side on.
// - While latched in overvoltage, an undervoltage turns both sides off and restarts after the hiccup delay.
// - If overvoltage still persists at that undervoltage, both sides stay off and no restart happens until it clears.
// - A low regulator supply stops switching, and switching resumes by itself when it recovers, with nothing latched.
// - Over-temperature shuts off switching without latching and recovers when it clears.
package bfp_pkg;
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int UV_DELAY_US = 1000;
  localparam int UV_ENABLE_US = 1500;
  localparam int HICCUP_US = 16000;
  localparam int UV_DELAY_CYCLES = UV_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int UV_ENABLE_CYCLES = UV_ENABLE_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int HICCUP_CYCLES = HICCUP_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int CNT_W = 32;

  typedef enum logic [2:0] {
    BFP_RUN = 3'b000,
    BFP_UV_OFF = 3'b001,
    BFP_HICCUP = 3'b011,
    BFP_OV_LOW_ON = 3'b010,
    BFP_OV_HOLD = 3'b110
  } bfp_state_type;
endpackage

// ===== src/bfp_sync.sv
`timescale 1ns/100ps
// three-stage input synchroniser; output changes when stages two and three agree
module bfp_sync (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      q_out <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      q_out <= s3_ff;
    end
  end
endmodule

// ===== src/bfp_delay_cnt.sv
`timescale 1ns/100ps
// counts cycles while cond_in holds; clears at once when it drops
module bfp_delay_cnt #(
  parameter int CNT_W = 32,
  parameter logic [31:0] LIMIT = 32'h0000_0001
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cond_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge clock_in) begin
    if (rst_in || !cond_in) begin
      cnt_ff <= '0;
    end else if (cnt_ff < LIMIT[CNT_W-1:0]) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign done_out = cond_in && (cnt_ff >= LIMIT[CNT_W-1:0]);
endmodule

// ===== verification/bfp_top_properties.sv
`timescale 1ns/100ps
module bfp_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic soft_start_done_in,
  input wire logic positive_current_limit_in,
  input wire logic fb_over_in,
  input wire logic supply_lockout_in,
  input wire logic over_temp_in,
  input wire logic high_side_out,
  input wire logic low_side_out,
  input wire logic undervoltage_protect_out,
  input wire logic overvoltage_protect_out,
  input wire logic restart_out,
  input wire logic shutdown_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  no_overlap_a: assert property (!(high_side_out && low_side_out))
    else $error("both drives on");
  shut_off_a: assert property (shutdown_out |-> !high_side_out && !low_side_out)
    else $error("drive on in shutdown");
  lockout_off_a: assert property (supply_lockout_in [*8] |-> !high_side_out && !low_side_out)
    else $error("drive on in lockout");
  temp_off_a: assert property (over_temp_in [*8] |-> !high_side_out && !low_side_out)
    else $error("drive on when hot");
  ov_latch_a: assert property (fb_over_in [*8] |-> overvoltage_protect_out && !high_side_out)
    else $error("no overvoltage action");
  limit_hold_a: assert property (positive_current_limit_in [*6] ##0 low_side_out |=> !high_side_out)
    else $error("high side during limit");
  restart_pulse_a: assert property (restart_out |=> !restart_out)
    else $error("restart not a pulse");
  uv_unarmed_a: assert property (!soft_start_done_in [*8] ##0 !overvoltage_protect_out |-> !undervoltage_protect_out)
    else $error("undervoltage while unarmed");
endmodule
bind bfp_top bfp_checker chk_i (.*);

// ===== verification/bfp_power_stage.sv
`timescale 1ns/100ps
module bfp_power_stage (
  input wire logic clock_in,
  input wire logic high_in,
  input wire logic low_in,
  input wire logic ccm_in,
  input wire logic overload_in,
  output logic pos_limit_out,
  output logic neg_limit_out
);
  int cur = 0;
  always @(posedge clock_in) begin
    if (high_in && (overload_in ? cur < 120 : cur < 40)) cur <= cur + (overload_in ? 8 : 1);
    else if (low_in && cur > -70) cur <= cur - 1;
    else if (!high_in && !low_in && cur > 0) cur <= cur - 1;
  end
  assign pos_limit_out = cur > 60;
  assign neg_limit_out = ccm_in && cur < -60;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic lk, tp, h, l, eh, el;} bfp_row_type;
  logic clock_in = 0, rst_in = 1, high_side_req_in = 0, low_side_req_in = 0;
  logic continuous_conduction_in = 1, soft_start_done_in = 0, fb_under_in = 0;
  logic fb_over_in = 0, supply_lockout_in = 0, over_temp_in = 0, ovl = 0;
  logic positive_current_limit_in, negative_current_limit_in, high_side_out, low_side_out;
  logic undervoltage_protect_out, overvoltage_protect_out, restart_out, shutdown_out;
  int n_fail = 0, samples_checked = 0, cyc = 0, k;
  bfp_row_type rows [6] = '{6'h0A, 6'h05, 6'h0E, 6'h28, 6'h14, 6'h05};
  bfp_top #(.UV_DELAY_CYCLES(20), .UV_ENABLE_CYCLES(30), .HICCUP_CYCLES(50)) dut (.*);
  bfp_power_stage stage (.clock_in(clock_in), .high_in(high_side_out), .low_in(low_side_out),
    .ccm_in(continuous_conduction_in), .overload_in(ovl),
    .pos_limit_out(positive_current_limit_in), .neg_limit_out(negative_current_limit_in));
  always #2.5 clock_in = ~clock_in;
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic a, input logic e);
    samples_checked++;
    if (a !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %b want %b", $time, a, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask
  initial begin
    tick(16);
    chk(high_side_out, 1'b0);
    chk(shutdown_out, 1'b0);
    rst_in = 0;
    foreach (rows[i]) begin
      {supply_lockout_in, over_temp_in, high_side_req_in, low_side_req_in} = rows[i][5:2];
      tick(8);
      chk(high_side_out, rows[i].eh);
      chk(low_side_out, rows[i].el);
    end
    {soft_start_done_in, high_side_req_in, low_side_req_in} = 3'h6;
    tick(40);
    fb_under_in = 1;
    tick(10);
    chk(high_side_out, 1'b1);
    chk(undervoltage_protect_out, 1'b1);
    tick(22);
    chk(high_side_out, 1'b0);
    fb_under_in = 0;
    wait_hi(restart_out, 80);
    chk(k >= 35 && k < 60, 1'b1);
    tick(3);
    chk(high_side_out, 1'b1);
    fb_under_in = 1;
    tick(25);
    chk(high_side_out, 1'b1);
    tick(40);
    chk(high_side_out, 1'b0);
    fb_under_in = 0;
    wait_hi(restart_out, 80);
    tick(3);
    fb_over_in = 1;
    tick(8);
    chk(low_side_out, 1'b1);
    chk(high_side_out, 1'b0);
    fb_under_in = 1;
    tick(8);
    chk(low_side_out, 1'b0);
    fb_under_in = 0;
    tick(60);
    chk(low_side_out | high_side_out, 1'b0);
    fb_over_in = 0;
    wait_hi(restart_out, 80);
    chk(restart_out, 1'b1);
    {ovl, high_side_req_in, low_side_req_in} = 3'h6;
    tick(20);
    {high_side_req_in, low_side_req_in} = 2'h1;
    tick(6);
    high_side_req_in = 1;
    tick(5);
    chk(high_side_out, 1'b0);
    ovl = 0;
    wait_hi(high_side_out, 150);
    chk(high_side_out, 1'b1);
    test_done();
  end
endmodule
